// ===== frsp_ctrl.sv
// row self-programming controller: registers, unlock, write latches, operation sequencing
// Functional notes
// - erase or program one 32-instruction row
// - panels of 128 rows, 4K instructions
// - 32 latches indexed by EA bits 5:1
// - low table ops reach bits 15:0
// - high table ops reach bits 23:16
// - address is page byte above EA
// - latch writes finish in two cycles
// - low address captures EA 15:0
// - upper address captures the table page byte
// - software may write address registers directly
// - key 0x55 then 0xAA unlocks start
// - start bit 15 cleared by hardware
// - operation lasts 2 ms, core stalls
// - software can set start, never clear
// - start needs write enable set earlier
// - reset abort sets error, address kept
// - completion sets flag, software clears it
`timescale 1ns/1ps
`include "frsp_defines.svh"

module frsp_ctrl #(
  parameter int OP_CYCLES = `FRSP_OP_CYCLES
) (
  input  wire logic                    mclk,
  input  wire logic                    reset,
  input  wire frsp_pkg::frsp_reg_req_s reg_req,
  output logic [15:0]                  reg_rdata,
  input  wire frsp_pkg::frsp_tbl_req_s tbl_req,
  output logic [15:0]                  tbl_rdata,
  output logic                         tbl_done,
  output logic [23:0]                  flash_rd_addr,
  input  wire logic [23:0]             flash_rd_data,
  output logic                         flash_op_start,
  output logic [6:0]                   flash_op_select,
  output logic [23:0]                  flash_row_addr,
  output logic [6:0]                   flash_panel,
  input  wire logic [4:0]              latch_rd_idx,
  output logic [23:0]                  latch_rd_data,
  output logic                         cpu_stall,
  input  wire logic                    abort_reset_in,
  output logic                         op_complete_flag,
  input  wire logic                    flag_clear
);
  import frsp_pkg::*;

  // =====================================================================
  // functions
  // place a 16-bit part into, or take it from, a 24-bit program word
  function automatic logic [23:0] frsp_merge(input logic [23:0] old, input logic [15:0] d,
                                              input logic hi, input logic bm, input logic odd);
    logic [23:0] w;
    w = old;
    if (hi) begin
      if (!bm || !odd) w[23:16] = d[7:0];
    end else if (!bm) begin
      w[15:0] = d;
    end else if (odd) begin
      w[15:8] = d[7:0];
    end else begin
      w[7:0] = d[7:0];
    end
    return w;
  endfunction
  function automatic logic [15:0] frsp_part(input logic [23:0] w, input logic hi,
                                             input logic bm, input logic odd);
    if (hi) return (bm && odd) ? 16'h0000 : {8'h00, w[23:16]};
    if (!bm) return w[15:0];
    return odd ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
  endfunction

  // =====================================================================
  // state
  logic               start_bit, next_start_bit;     // operation running
  logic               write_enable_bit, next_write_enable_bit;               // write enable
  logic               write_error_bit, next_write_error_bit;             // aborted operation
  logic               write_interrupt_select, next_write_interrupt_select;               // write interrupt select
  logic [6:0]         opsel, next_opsel;             // operation select field
  logic [15:0]        adr_lo, next_adr_lo;           // address low
  logic [7:0]         adr_up, next_adr_up;           // address upper
  frsp_unlock_e       ustate, next_ustate;           // unlock progress
  logic [15:0]        next_reg_rdata;
  logic               next_flag, next_op_start, next_stall;
  logic               tbl_p1;                        // table pipeline stage
  frsp_tbl_req_s      tbl_q;                         // held table request
  logic [23:0]        latch [`FRSP_ROW_WORDS];       // row write latches
  logic               abort_s1, abort_s2;            // abort synchroniser
  logic               op_done;                       // timer end pulse
  logic               abort_hit;                     // abort during operation
  logic               start_req;                     // accepted start

  // =====================================================================
  // abort pin synchroniser
  always_ff @(posedge mclk) begin
    if (reset) begin
      abort_s1 <= 1'b0;
      abort_s2 <= 1'b0;
    end else begin
      abort_s1 <= abort_reset_in;
      abort_s2 <= abort_s1;
    end
  end
  assign abort_hit = abort_s2 && start_bit;
  // duration counter
  frsp_op_timer #(.CYCLES(OP_CYCLES)) u_timer (
    .mclk   (mclk),
    .reset  (reset),
    .start  (start_req),
    .cancel (abort_hit),
    .done   (op_done)
  );
  // =====================================================================
  // register file and unlock sequence
  always_comb begin
    next_start_bit = start_bit;
    next_write_enable_bit      = write_enable_bit;
    next_write_error_bit     = write_error_bit;
    next_write_interrupt_select      = write_interrupt_select;
    next_opsel     = opsel;
    next_adr_lo    = adr_lo;
    next_adr_up    = adr_up;
    next_ustate    = ustate;
    next_reg_rdata = 16'h0000;
    start_req      = 1'b0;
    // any register access leaves an unfinished unlock behind
    if (reg_req.wr || reg_req.rd) next_ustate = FRSP_LOCKED;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        `FRSP_ADDR_CONTROL:   next_reg_rdata = {start_bit, write_enable_bit, write_error_bit, 4'h0, write_interrupt_select, 1'b0, opsel};
        `FRSP_ADDR_ADR_LOW:   next_reg_rdata = adr_lo;
        `FRSP_ADDR_ADR_UPPER: next_reg_rdata = {8'h00, adr_up};
        default:              next_reg_rdata = 16'h0000;  // key reads as zero
      endcase
    end
    if (reg_req.wr && !start_bit) begin
      unique case (reg_req.addr)
        `FRSP_ADDR_CONTROL: begin
          next_write_enable_bit  = reg_req.wdata[`FRSP_BIT_WRITE_ENABLE_BIT];
          next_write_error_bit = reg_req.wdata[`FRSP_BIT_WRITE_ERROR_BIT];
          next_write_interrupt_select  = reg_req.wdata[`FRSP_BIT_WRITE_INTERRUPT_SELECT];
          next_opsel = reg_req.wdata[`FRSP_OPSEL_MSB:0];
          // start only when armed and write enable was set before
          if (reg_req.wdata[`FRSP_BIT_START] && ustate == FRSP_ARMED && write_enable_bit) begin
            next_start_bit = 1'b1;
            start_req      = 1'b1;
          end
        end
        `FRSP_ADDR_ADR_LOW:   next_adr_lo = reg_req.wdata;
        `FRSP_ADDR_ADR_UPPER: next_adr_up = reg_req.wdata[7:0];
        `FRSP_ADDR_KEY: begin
          if (reg_req.wdata[7:0] == `FRSP_KEY_FIRST) begin
            next_ustate = FRSP_GOT_FIRST;
          end else if (reg_req.wdata[7:0] == `FRSP_KEY_SECOND && ustate == FRSP_GOT_FIRST) begin
            next_ustate = FRSP_ARMED;
          end
        end
        default: ;
      endcase
    end
    // a table instruction refreshes the address registers
    if (tbl_req.valid && !start_bit) begin
      next_adr_lo = tbl_req.ea;
      next_adr_up = tbl_req.page;
    end
    // hardware end of operation: success or abort
    if (op_done || abort_hit) next_start_bit = 1'b0;
    if (abort_hit) next_write_error_bit = 1'b1;
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      start_bit <= 1'b0;
      write_enable_bit      <= 1'b0;
      write_error_bit     <= 1'b0;
      write_interrupt_select      <= 1'b0;
      opsel     <= 7'h00;
      adr_lo    <= `FRSP_ADR_RESET;
      adr_up    <= 8'h00;
      ustate    <= FRSP_LOCKED;
      reg_rdata <= 16'h0000;
    end else begin
      start_bit <= next_start_bit;
      write_enable_bit      <= next_write_enable_bit;
      write_error_bit     <= next_write_error_bit;
      write_interrupt_select      <= next_write_interrupt_select;
      opsel     <= next_opsel;
      adr_lo    <= next_adr_lo;
      adr_up    <= next_adr_up;
      ustate    <= next_ustate;
      reg_rdata <= next_reg_rdata;
    end
  end

  // =====================================================================
  // operation outputs, stall and completion flag
  always_comb begin
    next_op_start = start_req;
    next_stall    = next_start_bit;
    // set wins over a clear in the same cycle
    next_flag     = op_done || (op_complete_flag && !flag_clear);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      flash_op_start   <= 1'b0;
      flash_op_select  <= 7'h00;
      flash_row_addr   <= 24'h000000;
      flash_panel      <= 7'h00;
      cpu_stall        <= 1'b0;
      op_complete_flag <= 1'b0;
    end else begin
      flash_op_start   <= next_op_start;
      cpu_stall        <= next_stall;
      op_complete_flag <= next_flag;
      if (start_req) begin
        flash_op_select <= next_opsel;
        // row aligned on 32 instructions, panel of 128 rows
        flash_row_addr  <= {adr_up, adr_lo[15:`FRSP_ROW_SHIFT], 6'h00};
        // panel number is program address bits 19:13, 4K instructions each
        flash_panel     <= {adr_up[3:0], adr_lo[15:`FRSP_PANEL_SHIFT]};
      end
    end
  end

  // =====================================================================
  // table instructions: two-cycle pipeline to the latches or the array
  always_ff @(posedge mclk) begin
    if (reset) begin
      tbl_p1        <= 1'b0;
      tbl_q         <= '0;
      tbl_done      <= 1'b0;
      tbl_rdata     <= 16'h0000;
      flash_rd_addr <= 24'h000000;
      latch_rd_data <= 24'h000000;
    end else begin
      tbl_p1        <= tbl_req.valid && !start_bit;
      tbl_done      <= tbl_p1;
      latch_rd_data <= latch[latch_rd_idx];  // latch readout toward the array side
      if (tbl_req.valid && !start_bit) begin
        tbl_q         <= tbl_req;
        flash_rd_addr <= {tbl_req.page, tbl_req.ea};
      end
      if (tbl_p1 && !tbl_q.write) begin
        tbl_rdata <= frsp_part(flash_rd_data, tbl_q.high, tbl_q.byte_mode, tbl_q.ea[0]);
      end
    end
  end

  // latch index from the instruction offset in the row
  always_ff @(posedge mclk) begin
    if (tbl_p1 && tbl_q.write) begin
      latch[tbl_q.ea[5:1]] <= frsp_merge(latch[tbl_q.ea[5:1]], tbl_q.wdata, tbl_q.high,
                                         tbl_q.byte_mode, tbl_q.ea[0]);
    end
  end

  // =====================================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  AST_START_NEEDS_KEY: assert property (!start_bit ##1 start_bit |-> $past(ustate) == FRSP_ARMED)
    else $error("start without unlock");
  AST_START_NEEDS_WRITE_ENABLE_BIT: assert property (!start_bit ##1 start_bit |-> $past(write_enable_bit))
    else $error("start without earlier write enable");
  AST_WRONG_KEY: assert property (reg_req.wr && reg_req.addr == `FRSP_ADDR_KEY
      && reg_req.wdata[7:0] != `FRSP_KEY_FIRST && reg_req.wdata[7:0] != `FRSP_KEY_SECOND
      |=> ustate == FRSP_LOCKED)
    else $error("wrong key kept unlock");
  AST_SW_NO_CLEAR: assert property (start_bit && !op_done && !abort_hit |=> start_bit)
    else $error("start bit cleared early");
  AST_HW_CLEAR: assert property (op_done |=> !start_bit ##0 op_complete_flag)
    else $error("start bit not cleared at end");
  AST_STALL: assert property ($rose(start_bit) |-> cpu_stall && flash_op_start)
    else $error("core not stalled");
  AST_ABORT_ERR: assert property (abort_hit |=> write_error_bit && !start_bit && $stable(adr_lo))
    else $error("abort without error bit");
  AST_FLAG_HOLD: assert property (op_complete_flag && !flag_clear |=> op_complete_flag)
    else $error("flag lost without clear");
  AST_WRITE_ENABLE_BIT_KEPT: assert property (op_done && write_enable_bit |=> write_enable_bit)
    else $error("write enable cleared by hardware");
  AST_TBL_TWO: assert property (tbl_req.valid && !start_bit |-> ##2 tbl_done)
    else $error("table op not done in two cycles");
  AST_ADDR_CAP: assert property (tbl_req.valid && !start_bit
      |=> adr_lo == $past(tbl_req.ea) && adr_up == $past(tbl_req.page))
    else $error("address not captured");
  COV_START: cover property (start_req);
  COV_DONE: cover property (op_done);
  COV_ABORT: cover property (abort_hit);
  COV_LATCH_WR: cover property (tbl_p1 && tbl_q.write && tbl_q.high);

endmodule

// ===== frsp_defines.svh
// offsets, field positions, reset values and timing counts of the row self-programmer
`ifndef FRSP_DEFINES_SVH
`define FRSP_DEFINES_SVH

// =====================================================================
// register addresses
`define FRSP_ADDR_CONTROL   16'h0760
`define FRSP_ADDR_ADR_LOW   16'h0762
`define FRSP_ADDR_ADR_UPPER 16'h0764
`define FRSP_ADDR_KEY       16'h0766

// =====================================================================
// control register fields
`define FRSP_BIT_START      15
`define FRSP_BIT_WRITE_ENABLE_BIT       14
`define FRSP_BIT_WRITE_ERROR_BIT      13
`define FRSP_BIT_WRITE_INTERRUPT_SELECT       8
`define FRSP_OPSEL_MSB      6
`define FRSP_CONTROL_RESET  16'h0000
`define FRSP_ADR_RESET      16'h0000

// =====================================================================
// unlock key values
`define FRSP_KEY_FIRST      8'h55
`define FRSP_KEY_SECOND     8'hAA

// =====================================================================
// flash geometry: 32 instructions a row, 128 rows a panel
`define FRSP_ROW_WORDS      32
`define FRSP_ROW_SHIFT      6
`define FRSP_PANEL_SHIFT    13

// =====================================================================
// timing: nominal operation time against a 40 ns clock
`define FRSP_OP_TIME_NS     2000000
`define FRSP_CLK_PERIOD_NS  40
`define FRSP_OP_CYCLES      (`FRSP_OP_TIME_NS / `FRSP_CLK_PERIOD_NS)
`define FRSP_TBL_CYCLES     2

`endif

// ===== frsp_pkg.sv
// types shared by the row self-programmer
package frsp_pkg;

  // =====================================================================
  // unlock sequence states
  typedef enum logic [1:0] {
    FRSP_LOCKED,
    FRSP_GOT_FIRST,
    FRSP_ARMED
  } frsp_unlock_e;

  // =====================================================================
  // register access from the core
  typedef struct packed {
    logic        wr;     // write strobe
    logic        rd;     // read strobe
    logic [15:0] addr;   // register address
    logic [15:0] wdata;  // write data
  } frsp_reg_req_s;

  // table instruction from the core
  typedef struct packed {
    logic        valid;      // one-cycle request
    logic        write;      // 1 write, 0 read
    logic        high;       // high part (bits 23:16)
    logic        byte_mode;  // byte access
    logic [7:0]  page;       // table page register bits 7:0
    logic [15:0] ea;         // effective address
    logic [15:0] wdata;      // write data
  } frsp_tbl_req_s;

endpackage

// ===== frsp_op_timer.sv
// operation duration counter of the row self-programmer
`timescale 1ns/1ps
`include "frsp_defines.svh"

module frsp_op_timer #(
  parameter int CYCLES = `FRSP_OP_CYCLES
) (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic start,
  input  wire logic cancel,
  output logic      done
);
  import frsp_pkg::*;

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count;       // cycles still to run
  logic [CW-1:0] next_count;
  logic          next_done;

  // =====================================================================
  // count down, pulse done on the last cycle
  always_comb begin
    next_count = count;
    next_done  = 1'b0;
    if (cancel) begin
      next_count = '0;
    end else if (start) begin
      next_count = CW'(CYCLES);
    end else if (count != '0) begin
      next_count = count - 1'b1;
      next_done  = (count == CW'(1));
    end
  end

  // register
  always_ff @(posedge mclk) begin
    if (reset) begin
      count <= '0;
      done  <= 1'b0;
    end else begin
      count <= next_count;
      done  <= next_done;
    end
  end

endmodule

// ===== frsp_array_model.sv
// flash array stand-in: read data from the address, latch readout scanner
`timescale 1ns/1ps

module frsp_array_model #(
  parameter logic [23:0] SCRAMBLE = 24'hA5C3E1
) (
  input  wire logic [0:0]  mclk,
  input  wire logic [23:0] flash_rd_addr,
  output logic      [23:0] flash_rd_data,
  output logic      [4:0]  latch_rd_idx,
  input  wire logic [23:0] latch_rd_data
);
  logic [4:0]  scan_idx = 5'h00;  // next latch to read
  logic [4:0]  idx_d1;     // index presented one edge ago
  logic [23:0] seen [32];  // latch words as read back

  // =====================================================================
  // array word is a fixed scramble of its address, answered at once
  assign flash_rd_data = flash_rd_addr ^ SCRAMBLE;

  // =====================================================================
  // walk all 32 latches in ascending order, one word a cycle
  assign latch_rd_idx = scan_idx;
  always @(posedge mclk) begin
    idx_d1       <= scan_idx;
    seen[idx_d1] <= latch_rd_data;
    scan_idx     <= scan_idx + 5'h01;
  end
endmodule

// ===== test_flash_row_self_programmer.sv
// self-checking bench for the row self-programmer controller
`timescale 1ns/1ps
`include "frsp_defines.svh"

module test_flash_row_self_programmer;
  import frsp_pkg::*;
  localparam int          OPC = 20;          // shortened operation length
  localparam logic [23:0] SCR = 24'hA5C3E1;  // array read scramble
  logic          mclk, reset, tbl_done, flash_op_start, cpu_stall, rd_seen;
  logic          abort_reset_in, op_complete_flag, flag_clear;
  frsp_reg_req_s reg_req;                    // register request
  frsp_tbl_req_s tbl_req;                    // table request
  logic [15:0]   reg_rdata, tbl_rdata;
  logic [23:0]   flash_rd_addr, flash_rd_data, flash_row_addr, latch_rd_data;
  logic [6:0]    flash_op_select, flash_panel;
  logic [4:0]    latch_rd_idx;
  logic [15:0]   rd_q[$];                    // expected register reads
  logic [31:0]   tb_q[$];                    // expected table results {mask, value}
  logic [37:0]   op_q[$];                    // expected launches {row, select, panel}
  logic [23:0]   exp_latch[32];              // words loaded into the latches
  logic [31:0]   tw;                         // table note being compared
  int            miscompares, num_checks, tbl_age;

  frsp_ctrl #(.OP_CYCLES(OPC)) uut (.mclk(mclk), .reset(reset), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .tbl_req(tbl_req), .tbl_rdata(tbl_rdata), .tbl_done(tbl_done),
    .flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data),
    .flash_op_start(flash_op_start), .flash_op_select(flash_op_select),
    .flash_row_addr(flash_row_addr), .flash_panel(flash_panel),
    .latch_rd_idx(latch_rd_idx), .latch_rd_data(latch_rd_data), .cpu_stall(cpu_stall),
    .abort_reset_in(abort_reset_in), .op_complete_flag(op_complete_flag),
    .flag_clear(flag_clear));

  frsp_array_model #(.SCRAMBLE(SCR)) partner (.mclk(mclk), .flash_rd_addr(flash_rd_addr),
    .flash_rd_data(flash_rd_data), .latch_rd_idx(latch_rd_idx),
    .latch_rd_data(latch_rd_data));

  // =====================================================================
  // clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // =====================================================================
  // compare, verdict
  task automatic chk(input string what, input logic [37:0] exp, input logic [37:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // =====================================================================
  // register bus: one access a cycle, idle drops the strobes
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
  endtask

  task automatic idle;
    @(posedge mclk);
    reg_req <= '0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    rd_q.push_back(e);
    acc(1'b0, a, 16'h0000);
    idle();
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    acc(1'b1, a, d);
    idle();
  endtask

  // key pair then control write, as consecutive accesses
  task automatic seq3(input logic [15:0] k1, input logic [15:0] k2, input logic [15:0] c);
    acc(1'b1, `FRSP_ADDR_KEY, k1);
    acc(1'b1, `FRSP_ADDR_KEY, k2);
    acc(1'b1, `FRSP_ADDR_CONTROL, c);
    idle();
  endtask

  // table instruction, four cycles apart at least
  task automatic tbl(input logic w, input logic hi, input logic bm, input logic [7:0] pg,
                     input logic [15:0] ea, input logic [15:0] d, input logic [31:0] e,
                     input bit push);
    if (push) tb_q.push_back(e);
    @(posedge mclk);
    tbl_req <= '{valid: 1'b1, write: w, high: hi, byte_mode: bm, page: pg, ea: ea, wdata: d};
    @(posedge mclk);
    tbl_req.valid <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  // full erase or program; with abort, a refused table read and a reset cut it short
  task automatic run_op(input logic [6:0] sel, input logic [15:0] lo, input logic [7:0] up,
                        input bit abort);
    int n;
    wr(`FRSP_ADDR_ADR_LOW, lo);
    wr(`FRSP_ADDR_ADR_UPPER, {8'h00, up});
    rd(`FRSP_ADDR_ADR_LOW, lo);
    rd(`FRSP_ADDR_ADR_UPPER, {8'h00, up});
    wr(`FRSP_ADDR_CONTROL, 16'h4000 | 16'(sel));
    op_q.push_back({up, lo[15:6], 6'h00, sel, up[3:0], lo[15:13]});
    seq3(16'h0055, 16'h00AA, 16'hC000 | 16'(sel));
    if (abort) begin
      tbl(1'b0, 1'b0, 1'b0, up, lo, 16'h0000, 32'h0, 1'b0);
      abort_reset_in <= 1'b1;
    end
    n = 0;
    @(posedge mclk);
    while (cpu_stall !== 1'b0 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 200) begin
      miscompares++;
      complete_run();
    end
    abort_reset_in <= 1'b0;
    if (abort) chk("abort stop", 1'b1, n <= 8);
    else chk("stall length", 1'b1, n >= OPC - 2 && n <= OPC + 3);
    chk("complete flag", !abort, op_complete_flag);
    rd(`FRSP_ADDR_CONTROL, (abort ? 16'h6000 : 16'h4000) | 16'(sel));
    rd(`FRSP_ADDR_ADR_LOW, lo);
    @(posedge mclk);
    flag_clear <= 1'b1;
    @(posedge mclk);
    flag_clear <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("flag cleared", 1'b0, op_complete_flag);
    wr(`FRSP_ADDR_CONTROL, 16'h4000 | 16'(sel));
  endtask

  // =====================================================================
  // watcher: each result takes the oldest note of its kind
  always @(posedge mclk) begin
    tbl_age = tbl_req.valid ? 0 : tbl_age + 1;
    if (rd_seen) begin
      if (rd_q.size() == 0) chk("stray reg read", 1'b0, 1'b1);
      else chk("reg_rdata", rd_q.pop_front(), reg_rdata);
    end
    if (tbl_done) begin
      if (tb_q.size() == 0) chk("stray tbl_done", 1'b0, 1'b1);
      else begin
        tw = tb_q.pop_front();
        chk("tbl_rdata", tw[15:0], tbl_rdata & tw[31:16]);
        chk("tbl_done delay", 38'd2, 38'(tbl_age));
      end
    end
    if (flash_op_start) begin
      if (op_q.size() == 0) chk("stray launch", 1'b0, 1'b1);
      else chk("launch", op_q.pop_front(), {flash_row_addr, flash_op_select, flash_panel});
    end
    rd_seen = reg_req.rd;
  end

  // =====================================================================
  // main sequence
  initial begin
    logic [7:0]  pg;
    logic [15:0] ea, lo, hi;
    logic [23:0] w;
    logic [31:0] e;
    void'($urandom(81337));
    reset = 1'b1;
    reg_req = '0;
    tbl_req = '0;
    abort_reset_in = 1'b0;
    flag_clear = 1'b0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    rd(`FRSP_ADDR_CONTROL, `FRSP_CONTROL_RESET);
    rd(`FRSP_ADDR_ADR_LOW, 16'h0000);
    rd(`FRSP_ADDR_ADR_UPPER, 16'h0000);
    rd(`FRSP_ADDR_KEY, 16'h0000);
    rd(16'h0768, 16'h0000);
    $display("test reset values done");
    seq3(16'h0055, 16'h00AA, 16'hC041);
    rd(`FRSP_ADDR_CONTROL, 16'h4041);
    seq3(16'h0055, 16'h0012, 16'hC041);
    rd_q.push_back(16'h0000);
    acc(1'b1, `FRSP_ADDR_KEY, 16'h0055);
    acc(1'b0, `FRSP_ADDR_ADR_LOW, 16'h0000);
    seq3(16'h00AA, 16'h00AA, 16'hC041);
    rd(`FRSP_ADDR_CONTROL, 16'h4041);
    $display("test refused unlocks done");
    pg = 8'($urandom);
    ea = 16'($urandom) & 16'hFFC0;
    for (int i = 0; i < 32; i++) begin
      lo = 16'($urandom);
      hi = 16'($urandom);
      exp_latch[i] = {hi[7:0], lo};
      tbl(1'b1, 1'b0, 1'b0, pg, ea + 16'(2 * i), lo, 32'h0, 1'b1);
      tbl(1'b1, 1'b1, 1'b0, pg, ea + 16'(2 * i), hi, 32'h0, 1'b1);
    end
    rd(`FRSP_ADDR_ADR_LOW, ea + 16'd62);
    rd(`FRSP_ADDR_ADR_UPPER, {8'h00, pg});
    repeat (34) @(posedge mclk);
    for (int i = 0; i < 32; i++) begin
      chk("latch word", exp_latch[i], partner.seen[i]);
    end
    $display("test latch load done");
    for (int i = 0; i < 8; i++) begin
      pg = 8'($urandom);
      ea = 16'($urandom);
      ea[0] = i[1] & i[0];
      w = {pg, ea} ^ SCR;
      e = i[0] ? (i[1] ? 32'hFFFF_0000 : {24'h00FF_00, w[23:16]})
               : (i[1] ? {24'h00FF_00, w[7:0]} : {16'hFFFF, w[15:0]});
      tbl(1'b0, i[0], i[1], pg, ea, 16'h0000, e, 1'b1);
    end
    $display("test table reads done");
    run_op(7'h41, 16'($urandom), 8'($urandom), 1'b0);
    run_op(7'h01, 16'($urandom), 8'($urandom), 1'b0);
    $display("test erase and program done");
    run_op(7'h01, 16'($urandom), 8'($urandom), 1'b1);
    $display("test abort done");
    repeat (4) @(posedge mclk);
    chk("notes left", 38'd0, 38'(rd_q.size() + tb_q.size() + op_q.size()));
    complete_run();
  end
endmodule
